// ---- src/cpu_dedicated_register_set.sv ----
// Notes on behaviour
// RQ1 - One flat 64-Kbyte space holds I/O, data and program areas.
// RQ2 - I/O region starts at address zero.
// RQ3 - Data region starts right above the I/O region.
// RQ4 - Data region split into banks, stack and direct areas by software.
// RQ5 - Program region sits at the top of the space.
// RQ6 - Vector tables occupy the highest program addresses.
// RQ7 - Sixteen-bit program counter points at the fetched instruction.
// RQ8 - Sixteen-bit main accumulator; byte operations use its low byte.
// RQ9 - Sixteen-bit temporary accumulator is the second operand; byte mode uses low byte.
// RQ10 - Sixteen-bit index register offsets indexed addresses.
// RQ11 - Sixteen-bit extra pointer gives a memory address for pointer accesses.
// RQ12 - Sixteen-bit stack pointer marks the current stack location.
// RQ13 - Status word: upper byte bank pointer, lower byte condition flags.
// RQ14 - Bank pointer maps to the active bank address by fixed conversion.
// RQ15 - Each bank holds eight byte registers; thirty-two banks selectable.
// RQ16 - Interrupt enable flag clears at reset.
// RQ17 - Interrupt taken only when its level beats the current level; zero highest.
// RQ18 - Half-carry flag follows carry or borrow between bit 3 and 4.
// RQ19 - Byte writes to accumulators keep the upper byte.
`timescale 1ns/10ps
module cpu_dedicated_register_set #(
    parameter logic [15:0] IO_TOP = cpu_regs_pkg::IO_TOP_DEFAULT,
    parameter logic [15:0] DATA_TOP = cpu_regs_pkg::DATA_TOP_DEFAULT,
    parameter logic [15:0] PROG_BASE = cpu_regs_pkg::PROG_BASE_DEFAULT,
    parameter logic [15:0] VECTOR_BASE = cpu_regs_pkg::VECTOR_BASE_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Software register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Core control
    input wire logic fetch_adv_i,
    input wire logic [1:0] fetch_len_i,
    input wire logic jump_i,
    input wire logic [15:0] jump_addr_i,
    input wire logic alu_en_i,
    input wire logic [2:0] alu_op_i,
    input wire logic alu_byte_i,
    input wire logic acc_load_i,
    input wire logic [15:0] acc_load_data_i,
    input wire logic load_byte_i,
    input wire logic acc_to_tmp_i,
    input wire logic stack_push_i,
    input wire logic stack_pop_i,
    input wire logic [7:0] index_disp_i,
    input wire logic [2:0] bank_reg_sel_i,
    input wire logic [15:0] mem_addr_i,
    // Interrupt request
    input wire logic irq_req_i,
    input wire logic [1:0] irq_level_i,
    output logic irq_accept_o,
    // Addresses and decode
    output logic [15:0] fetch_addr_o,
    output logic [15:0] indexed_addr_o,
    output logic [15:0] pointer_addr_o,
    output logic [15:0] stack_addr_o,
    output logic [15:0] bank_reg_addr_o,
    output logic in_io_o,
    output logic in_data_o,
    output logic in_prog_o,
    output logic in_vector_o,
    output logic [15:0] acc_o,
    output logic [7:0] flags_o
);
    if (!(IO_TOP < DATA_TOP && DATA_TOP < PROG_BASE && PROG_BASE <= VECTOR_BASE)) begin : g_bad_regions
        $error("cpu_dedicated_register_set: regions overlap or are out of order");
    end

    logic [15:0] program_counter;
    logic [15:0] main_accumulator;
    logic [15:0] temp_accumulator;
    logic [15:0] index_reg;
    logic [15:0] extra_pointer;
    logic [15:0] stack_pointer;
    logic [7:0] bank_select_pointer;
    logic [7:0] condition_flags;
    logic [15:0] program_status;

    logic [15:0] next_pc;
    logic [15:0] next_acc;
    logic [15:0] next_tmp;
    logic [15:0] next_sp;
    logic [7:0] next_flags;
    logic [15:0] rdata_mux;

    alu_link_if alu_bus ();

    cpu_alu u_alu (
        .link(alu_bus)
    );

    assign alu_bus.op_a = main_accumulator;
    assign alu_bus.op_b = temp_accumulator; // RQ9
    assign alu_bus.byte_mode = alu_byte_i;
    assign alu_bus.carry_in = condition_flags[cpu_regs_pkg::FLAG_C];
    assign alu_bus.op = cpu_regs_pkg::alu_op_e'(alu_op_i);

    // Software write decode
    wire wr_pc = reg_wr_i && (reg_addr_i == cpu_regs_pkg::REG_PC);
    wire wr_acc = reg_wr_i && (reg_addr_i == cpu_regs_pkg::REG_ACC);
    wire wr_tmp = reg_wr_i && (reg_addr_i == cpu_regs_pkg::REG_TMP);
    wire wr_idx = reg_wr_i && (reg_addr_i == cpu_regs_pkg::REG_IDX);
    wire wr_exp = reg_wr_i && (reg_addr_i == cpu_regs_pkg::REG_EXP);
    wire wr_stk = reg_wr_i && (reg_addr_i == cpu_regs_pkg::REG_STK);
    wire wr_psw = reg_wr_i && (reg_addr_i == cpu_regs_pkg::REG_PSW);

    assign program_status = {bank_select_pointer, condition_flags}; // RQ13

    // Program counter: jump wins over sequential advance
    always_comb begin
        next_pc = program_counter;
        if (wr_pc) begin
            next_pc = reg_wdata_i;
        end else if (jump_i) begin
            next_pc = jump_addr_i;
        end else if (fetch_adv_i) begin
            next_pc = program_counter + {14'h0000, fetch_len_i}; // RQ7
        end
    end

    // Accumulator: byte results keep the upper byte
    always_comb begin
        next_acc = main_accumulator;
        if (wr_acc) begin
            next_acc = reg_wdata_i;
        end else if (alu_en_i) begin
            next_acc = alu_byte_i ? {main_accumulator[15:8], alu_bus.result[7:0]} : alu_bus.result; // RQ8 RQ19
        end else if (acc_load_i) begin
            next_acc = load_byte_i ? {main_accumulator[15:8], acc_load_data_i[7:0]} : acc_load_data_i; // RQ19
        end
    end

    always_comb begin
        next_tmp = temp_accumulator;
        if (wr_tmp) begin
            next_tmp = reg_wdata_i;
        end else if (acc_to_tmp_i) begin
            next_tmp = load_byte_i ? {temp_accumulator[15:8], main_accumulator[7:0]} : main_accumulator; // RQ9 RQ19
        end
    end

    // Stack grows downward; push pre-decrements by a word
    always_comb begin
        next_sp = stack_pointer;
        if (wr_stk) begin
            next_sp = reg_wdata_i;
        end else if (stack_push_i && !stack_pop_i) begin
            next_sp = stack_pointer - 16'h0002; // RQ12
        end else if (stack_pop_i && !stack_push_i) begin
            next_sp = stack_pointer + 16'h0002; // RQ12
        end
    end

    // Arithmetic flags update; interrupt fields only change by software
    always_comb begin
        next_flags = condition_flags;
        if (wr_psw) begin
            next_flags = reg_wdata_i[7:0];
        end else if (alu_en_i) begin
            next_flags[cpu_regs_pkg::FLAG_C] = alu_bus.flags[cpu_regs_pkg::FLAG_C];
            next_flags[cpu_regs_pkg::FLAG_V] = alu_bus.flags[cpu_regs_pkg::FLAG_V];
            next_flags[cpu_regs_pkg::FLAG_Z] = alu_bus.flags[cpu_regs_pkg::FLAG_Z];
            next_flags[cpu_regs_pkg::FLAG_N] = alu_bus.flags[cpu_regs_pkg::FLAG_N];
            next_flags[cpu_regs_pkg::FLAG_H] = alu_bus.flags[cpu_regs_pkg::FLAG_H]; // RQ18
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            program_counter <= cpu_regs_pkg::PC_RESET;
            main_accumulator <= cpu_regs_pkg::WORD_RESET;
            temp_accumulator <= cpu_regs_pkg::WORD_RESET;
            stack_pointer <= cpu_regs_pkg::WORD_RESET;
            condition_flags <= cpu_regs_pkg::PSW_RESET[7:0]; // RQ16
            bank_select_pointer <= cpu_regs_pkg::PSW_RESET[15:8];
        end else if (ce_i) begin
            program_counter <= next_pc;
            main_accumulator <= next_acc;
            temp_accumulator <= next_tmp;
            stack_pointer <= next_sp;
            condition_flags <= next_flags;
            if (wr_psw) begin
                bank_select_pointer <= reg_wdata_i[15:8];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            index_reg <= cpu_regs_pkg::WORD_RESET;
            extra_pointer <= cpu_regs_pkg::WORD_RESET;
        end else if (ce_i) begin
            if (wr_idx) begin
                index_reg <= reg_wdata_i; // RQ10
            end
            if (wr_exp) begin
                extra_pointer <= reg_wdata_i; // RQ11
            end
        end
    end

    // Address generation
    assign fetch_addr_o = program_counter; // RQ7
    assign indexed_addr_o = index_reg + {{8{index_disp_i[7]}}, index_disp_i}; // RQ10
    assign pointer_addr_o = extra_pointer; // RQ11
    assign stack_addr_o = stack_pointer; // RQ12
    // Bank address = base + bank * 8 + register number
    assign bank_reg_addr_o = cpu_regs_pkg::BANK_BASE + {8'h00, bank_select_pointer[4:0], bank_reg_sel_i}; // RQ14 RQ15

    // Region decode over the single 16-bit space
    wire [16:0] addr_ext = {1'b0, mem_addr_i};
    wire addr_valid = addr_ext < cpu_regs_pkg::SPACE_BYTES; // RQ1
    assign in_io_o = addr_valid && (mem_addr_i >= cpu_regs_pkg::IO_BASE) && (mem_addr_i <= IO_TOP); // RQ2
    assign in_data_o = addr_valid && (mem_addr_i > IO_TOP) && (mem_addr_i <= DATA_TOP); // RQ3 RQ4
    assign in_prog_o = addr_valid && (mem_addr_i >= PROG_BASE); // RQ5
    assign in_vector_o = addr_valid && (mem_addr_i >= VECTOR_BASE); // RQ6

    // Interrupt admission: enabled and strictly more urgent than current level
    wire [1:0] cur_level = {condition_flags[cpu_regs_pkg::FLAG_IL1], condition_flags[cpu_regs_pkg::FLAG_IL0]};
    assign irq_accept_o = irq_req_i && condition_flags[cpu_regs_pkg::FLAG_I] && (irq_level_i < cur_level); // RQ17

    // Read data mux
    wire [15:0] region_word = {12'h000, in_vector_o, in_prog_o, in_data_o, in_io_o};
    wire [15:0] irq_word = {13'h0000, irq_accept_o, cur_level};
    always_comb begin
        case (reg_addr_i)
            cpu_regs_pkg::REG_PC: rdata_mux = program_counter;
            cpu_regs_pkg::REG_ACC: rdata_mux = main_accumulator;
            cpu_regs_pkg::REG_TMP: rdata_mux = temp_accumulator;
            cpu_regs_pkg::REG_IDX: rdata_mux = index_reg;
            cpu_regs_pkg::REG_EXP: rdata_mux = extra_pointer;
            cpu_regs_pkg::REG_STK: rdata_mux = stack_pointer;
            cpu_regs_pkg::REG_PSW: rdata_mux = program_status;
            cpu_regs_pkg::REG_BANK: rdata_mux = bank_reg_addr_o;
            cpu_regs_pkg::REG_REGION: rdata_mux = region_word;
            cpu_regs_pkg::REG_IRQ: rdata_mux = irq_word;
            default: rdata_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? rdata_mux : 16'h0000;
        end
    end

    assign acc_o = main_accumulator;
    assign flags_o = condition_flags;
endmodule // cpu_dedicated_register_set

// ---- src/cpu_regs_pkg.sv ----
package cpu_regs_pkg;
    // Memory space
    localparam int ADDR_W = 16;
    localparam logic [16:0] SPACE_BYTES = 17'h10000;
    localparam logic [15:0] IO_BASE = 16'h0000;
    localparam logic [15:0] IO_TOP_DEFAULT = 16'h007F;
    localparam logic [15:0] DATA_TOP_DEFAULT = 16'h087F;
    localparam logic [15:0] PROG_BASE_DEFAULT = 16'h1000;
    localparam logic [15:0] VECTOR_BASE_DEFAULT = 16'hFFC0;
    // Register bank conversion: bank address = BANK_BASE + rp[4:0] * 8
    localparam logic [15:0] BANK_BASE = 16'h0100;
    localparam int BANK_REGS = 8;
    localparam int BANK_COUNT = 32;
    // Register indices on the software port
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_ACC = 4'h1;
    localparam logic [3:0] REG_TMP = 4'h2;
    localparam logic [3:0] REG_IDX = 4'h3;
    localparam logic [3:0] REG_EXP = 4'h4;
    localparam logic [3:0] REG_STK = 4'h5;
    localparam logic [3:0] REG_PSW = 4'h6;
    localparam logic [3:0] REG_BANK = 4'h7;
    localparam logic [3:0] REG_REGION = 4'h8;
    localparam logic [3:0] REG_IRQ = 4'h9;
    // Condition flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_IL0 = 4;
    localparam int FLAG_IL1 = 5;
    localparam int FLAG_I = 6;
    localparam int FLAG_H = 7;
    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] PSW_RESET = 16'h0030;
    // ALU operations
    typedef enum logic [2:0] {
        ALU_ADD = 3'h0,
        ALU_SUB = 3'h1,
        ALU_AND = 3'h2,
        ALU_OR = 3'h3,
        ALU_XOR = 3'h4,
        ALU_SHL = 3'h5,
        ALU_SHR = 3'h6,
        ALU_PASS = 3'h7
    } alu_op_e;
endpackage

// ---- src/alu_link_if.sv ----
`timescale 1ns/10ps
interface alu_link_if;
    logic [15:0] op_a;
    logic [15:0] op_b;
    logic byte_mode;
    logic carry_in;
    cpu_regs_pkg::alu_op_e op;
    logic [15:0] result;
    logic [7:0] flags;
    modport core (output op_a, output op_b, output byte_mode, output carry_in, output op, input result, input flags);
    modport alu (input op_a, input op_b, input byte_mode, input carry_in, input op, output result, output flags);
endinterface

// ---- src/cpu_alu.sv ----
`timescale 1ns/10ps
module cpu_alu (
    alu_link_if.alu link
);
    logic [16:0] wide;
    logic [4:0] low_nib;
    logic [15:0] res;
    logic [7:0] flg;
    logic msb;
    logic carry;
    logic ovf;
    logic shout;
    logic [15:0] bmask;

    assign bmask = link.byte_mode ? 16'h00FF : 16'hFFFF;

    always_comb begin
        wide = 17'h00000;
        low_nib = 5'h00;
        shout = 1'b0;
        case (link.op)
            cpu_regs_pkg::ALU_ADD: begin
                wide = {1'b0, link.op_a & bmask} + {1'b0, link.op_b & bmask} + {16'h0000, link.carry_in};
                low_nib = {1'b0, link.op_a[3:0]} + {1'b0, link.op_b[3:0]} + {4'h0, link.carry_in};
            end
            cpu_regs_pkg::ALU_SUB: begin
                wide = {1'b0, link.op_a & bmask} - {1'b0, link.op_b & bmask} - {16'h0000, link.carry_in};
                low_nib = {1'b0, link.op_a[3:0]} - {1'b0, link.op_b[3:0]} - {4'h0, link.carry_in};
            end
            cpu_regs_pkg::ALU_AND: wide = {1'b0, link.op_a & link.op_b};
            cpu_regs_pkg::ALU_OR: wide = {1'b0, link.op_a | link.op_b};
            cpu_regs_pkg::ALU_XOR: wide = {1'b0, link.op_a ^ link.op_b};
            cpu_regs_pkg::ALU_SHL: begin
                wide = {1'b0, link.op_a[14:0], link.carry_in};
                shout = link.byte_mode ? link.op_a[7] : link.op_a[15];
            end
            cpu_regs_pkg::ALU_SHR: begin
                wide = link.byte_mode ? {9'h000, link.carry_in, link.op_a[7:1]} : {1'b0, link.carry_in, link.op_a[15:1]};
                shout = link.op_a[0];
            end
            default: wide = {1'b0, link.op_a};
        endcase
    end

    assign res = wide[15:0] & bmask;
    assign msb = link.byte_mode ? res[7] : res[15];
    assign carry = (link.op == cpu_regs_pkg::ALU_SHL || link.op == cpu_regs_pkg::ALU_SHR) ? shout :
                   (link.byte_mode ? wide[8] : wide[16]);
    assign ovf = (link.op == cpu_regs_pkg::ALU_ADD) ?
                 ((link.byte_mode ? (link.op_a[7] == link.op_b[7]) : (link.op_a[15] == link.op_b[15])) &&
                  (msb != (link.byte_mode ? link.op_a[7] : link.op_a[15]))) :
                 (link.op == cpu_regs_pkg::ALU_SUB) ?
                 ((link.byte_mode ? (link.op_a[7] != link.op_b[7]) : (link.op_a[15] != link.op_b[15])) &&
                  (msb != (link.byte_mode ? link.op_a[7] : link.op_a[15]))) : 1'b0;

    always_comb begin
        flg = 8'h00;
        flg[cpu_regs_pkg::FLAG_C] = carry;
        flg[cpu_regs_pkg::FLAG_V] = ovf;
        flg[cpu_regs_pkg::FLAG_Z] = (res == 16'h0000);
        flg[cpu_regs_pkg::FLAG_N] = msb;
        flg[cpu_regs_pkg::FLAG_H] = low_nib[4]; // RQ18
    end

    assign link.result = res;
    assign link.flags = flg;
endmodule // cpu_alu

// ---- verification/regs_chk.sv ----
`timescale 1ns/10ps
module regs_chk #(
    parameter logic [15:0] IO_TOP = cpu_regs_pkg::IO_TOP_DEFAULT,
    parameter logic [15:0] DATA_TOP = cpu_regs_pkg::DATA_TOP_DEFAULT,
    parameter logic [15:0] VECTOR_BASE = cpu_regs_pkg::VECTOR_BASE_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic fetch_adv_i,
    input wire logic [1:0] fetch_len_i,
    input wire logic jump_i,
    input wire logic alu_en_i,
    input wire logic alu_byte_i,
    input wire logic stack_push_i,
    input wire logic stack_pop_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic irq_req_i,
    input wire logic [1:0] irq_level_i,
    input wire logic irq_accept_o,
    input wire logic [15:0] fetch_addr_o,
    input wire logic [15:0] stack_addr_o,
    input wire logic in_io_o,
    input wire logic in_data_o,
    input wire logic in_vector_o,
    input wire logic [15:0] acc_o,
    input wire logic [7:0] flags_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_read_acc: assert property (ce_i && reg_rd_i && reg_addr_i == cpu_regs_pkg::REG_ACC |=> reg_rdata_o == $past(acc_o))
        else $error("read data differs from accumulator");
    a_rdata_idle: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside read");
    a_fetch_step: assert property (ce_i && fetch_adv_i && !jump_i && !reg_wr_i |=>
        fetch_addr_o == $past(fetch_addr_o) + {14'h0000, $past(fetch_len_i)})
        else $error("program counter step wrong");
    a_irq_gate: assert property (irq_accept_o == (irq_req_i && flags_o[cpu_regs_pkg::FLAG_I]
        && irq_level_i < flags_o[5:4]))
        else $error("interrupt accept wrong");
    a_region_io: assert property (in_io_o == (mem_addr_i <= IO_TOP))
        else $error("io region decode wrong");
    a_region_data: assert property (in_data_o == (mem_addr_i > IO_TOP && mem_addr_i <= DATA_TOP))
        else $error("data region decode wrong");
    a_vector_top: assert property (in_vector_o == (mem_addr_i >= VECTOR_BASE))
        else $error("vector region decode wrong");
    a_byte_upper: assert property (ce_i && alu_en_i && alu_byte_i && !reg_wr_i |=> $stable(acc_o[15:8]))
        else $error("byte operation changed upper byte");
    a_stack_push: assert property (ce_i && stack_push_i && !stack_pop_i && !reg_wr_i |=>
        stack_addr_o == $past(stack_addr_o) - 16'h0002)
        else $error("stack push step wrong");
    a_reset_irq_off: assert property ($fell(rst_i) |-> !flags_o[cpu_regs_pkg::FLAG_I])
        else $error("interrupts enabled after reset");
endmodule // regs_chk

bind cpu_dedicated_register_set regs_chk #(.IO_TOP(IO_TOP), .DATA_TOP(DATA_TOP), .VECTOR_BASE(VECTOR_BASE)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .fetch_adv_i(fetch_adv_i), .fetch_len_i(fetch_len_i), .jump_i(jump_i),
    .alu_en_i(alu_en_i), .alu_byte_i(alu_byte_i), .stack_push_i(stack_push_i), .stack_pop_i(stack_pop_i),
    .mem_addr_i(mem_addr_i), .irq_req_i(irq_req_i), .irq_level_i(irq_level_i), .irq_accept_o(irq_accept_o),
    .fetch_addr_o(fetch_addr_o), .stack_addr_o(stack_addr_o), .in_io_o(in_io_o), .in_data_o(in_data_o),
    .in_vector_o(in_vector_o), .acc_o(acc_o), .flags_o(flags_o));

// ---- verification/cpu_dedicated_register_set_tb.sv ----
`timescale 1ns/10ps
module cpu_dedicated_register_set_tb;
    logic clk_i, rst_i, ce_i, reg_wr_i, reg_rd_i, fetch_adv_i, jump_i, alu_en_i, alu_byte_i, acc_load_i;
    logic load_byte_i, acc_to_tmp_i, stack_push_i, stack_pop_i, irq_req_i, irq_accept_o;
    logic in_io_o, in_data_o, in_prog_o, in_vector_o;
    logic [3:0] reg_addr_i;
    logic [1:0] fetch_len_i, irq_level_i;
    logic [2:0] alu_op_i, bank_reg_sel_i;
    logic [7:0] index_disp_i, flags_o;
    logic [15:0] reg_wdata_i, jump_addr_i, acc_load_data_i, mem_addr_i, reg_rdata_o, fetch_addr_o, indexed_addr_o;
    logic [15:0] pointer_addr_o, stack_addr_o, bank_reg_addr_o, acc_o;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    cpu_dedicated_register_set uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .fetch_adv_i(fetch_adv_i), .fetch_len_i(fetch_len_i), .jump_i(jump_i), .jump_addr_i(jump_addr_i),
        .alu_en_i(alu_en_i), .alu_op_i(alu_op_i), .alu_byte_i(alu_byte_i), .acc_load_i(acc_load_i),
        .acc_load_data_i(acc_load_data_i), .load_byte_i(load_byte_i), .acc_to_tmp_i(acc_to_tmp_i),
        .stack_push_i(stack_push_i), .stack_pop_i(stack_pop_i), .index_disp_i(index_disp_i),
        .bank_reg_sel_i(bank_reg_sel_i), .mem_addr_i(mem_addr_i), .irq_req_i(irq_req_i), .irq_level_i(irq_level_i),
        .irq_accept_o(irq_accept_o), .fetch_addr_o(fetch_addr_o), .indexed_addr_o(indexed_addr_o),
        .pointer_addr_o(pointer_addr_o), .stack_addr_o(stack_addr_o), .bank_reg_addr_o(bank_reg_addr_o),
        .in_io_o(in_io_o), .in_data_o(in_data_o), .in_prog_o(in_prog_o), .in_vector_o(in_vector_o),
        .acc_o(acc_o), .flags_o(flags_o));

    always #10 clk_i = ~clk_i;

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("read data", exp, reg_rdata_o);
    endtask

    // Raise one core control (jump and fetch advance together for the default select) for a single cycle and let its edge land
    task automatic pulse(input int sel);
        @(posedge clk_i);
        case (sel)
            0: alu_en_i <= 1'b1;
            1: stack_push_i <= 1'b1;
            2: stack_pop_i <= 1'b1;
            3: fetch_adv_i <= 1'b1;
            5: acc_load_i <= 1'b1;
            6: acc_to_tmp_i <= 1'b1;
            default: {jump_i, fetch_adv_i} <= 2'b11;
        endcase
        @(posedge clk_i);
        {alu_en_i, stack_push_i, stack_pop_i, fetch_adv_i, jump_i, acc_load_i, acc_to_tmp_i} <= 7'h00;
        #1;
    endtask

    task automatic t_reset();
        rd(cpu_regs_pkg::REG_PSW, 16'h0030);
        chk("flags", 16'h0030, 16'(flags_o));
        rd(4'hF, 16'h0000);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 6; i++) wr(4'(i), 16'(i + 1) * 16'h1111);
        for (int i = 0; i < 6; i++) rd(4'(i), 16'(i + 1) * 16'h1111);
        wr(4'hF, 16'hBEEF);
        rd(4'hF, 16'h0000);
    endtask

    task automatic t_alu();
        wr(cpu_regs_pkg::REG_PSW, 16'h0000);
        wr(cpu_regs_pkg::REG_ACC, 16'h120F);
        wr(cpu_regs_pkg::REG_TMP, 16'h0001);
        alu_op_i <= 3'h0;
        alu_byte_i <= 1'b1;
        pulse(0);
        chk("acc", 16'h1210, acc_o);
        chk("flags", 16'h0080, 16'(flags_o));
        wr(cpu_regs_pkg::REG_TMP, 16'h0010);
        pulse(0);
        chk("acc", 16'h1220, acc_o);
        chk("flags", 16'h0000, 16'(flags_o));
        wr(cpu_regs_pkg::REG_TMP, 16'h0001);
        alu_op_i <= 3'h1;
        pulse(0);
        chk("acc", 16'h121F, acc_o);
        chk("flags", 16'h0080, 16'(flags_o));
        load_byte_i <= 1'b1;
        acc_load_data_i <= 16'hABCD;
        pulse(5);
        chk("acc", 16'h12CD, acc_o);
        pulse(6);
        rd(cpu_regs_pkg::REG_TMP, 16'h00CD);
        load_byte_i <= 1'b0;
        alu_byte_i <= 1'b0;
    endtask

    task automatic t_fetch();
        wr(cpu_regs_pkg::REG_PC, 16'h1000);
        fetch_len_i <= 2'h3;
        pulse(3);
        chk("pc", 16'h1003, fetch_addr_o);
        jump_addr_i <= cpu_regs_pkg::VECTOR_BASE_DEFAULT;
        pulse(4);
        chk("pc", cpu_regs_pkg::VECTOR_BASE_DEFAULT, fetch_addr_o);
    endtask

    task automatic t_region();
        logic [15:0] tbl [10] = '{16'h0000, 16'h007F, 16'h0080, 16'h087F, 16'h0880, 16'h0FFF, 16'h1000,
            16'hFFBF, 16'hFFC0, 16'hFFFF};
        logic [3:0] exp;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            mem_addr_i <= tbl[i];
            #1;
            exp = {tbl[i] >= cpu_regs_pkg::VECTOR_BASE_DEFAULT, tbl[i] >= cpu_regs_pkg::PROG_BASE_DEFAULT,
                tbl[i] > cpu_regs_pkg::IO_TOP_DEFAULT && tbl[i] <= cpu_regs_pkg::DATA_TOP_DEFAULT,
                tbl[i] <= cpu_regs_pkg::IO_TOP_DEFAULT};
            chk("region", 16'(exp), 16'({in_vector_o, in_prog_o, in_data_o, in_io_o}));
        end
    endtask

    task automatic t_bank_irq();
        wr(cpu_regs_pkg::REG_PSW, 16'h1F60);
        chk("flags", 16'h0060, 16'(flags_o));
        bank_reg_sel_i <= 3'h7;
        rd(cpu_regs_pkg::REG_BANK, 16'h01FF);
        chk("bank reg", 16'h01FF, bank_reg_addr_o);
        wr(cpu_regs_pkg::REG_BANK, 16'h0000);
        rd(cpu_regs_pkg::REG_BANK, 16'h01FF);
        irq_req_i <= 1'b1;
        for (int l = 0; l < 4; l++) begin
            irq_level_i <= 2'(l);
            @(posedge clk_i);
            #1;
            chk("accept", 16'(l < 2), 16'(irq_accept_o));
        end
        wr(cpu_regs_pkg::REG_PSW, 16'h0000);
        chk("accept", 16'h0000, 16'(irq_accept_o));
    endtask

    task automatic t_ptrs();
        wr(cpu_regs_pkg::REG_STK, 16'h0880);
        wr(cpu_regs_pkg::REG_IDX, 16'h0100);
        wr(cpu_regs_pkg::REG_EXP, 16'h0456);
        index_disp_i <= 8'hFE;
        pulse(1);
        chk("stack", 16'h087E, stack_addr_o);
        pulse(2);
        chk("stack", 16'h0880, stack_addr_o);
        chk("indexed", 16'h00FE, indexed_addr_o);
        chk("pointer", 16'h0456, pointer_addr_o);
    endtask

    // Clock enable low freezes state; a reset in mid-run clears the interrupt enable again
    task automatic t_rerst();
        wr(cpu_regs_pkg::REG_PSW, 16'h0040);
        ce_i <= 1'b0;
        pulse(3);
        chk("pc frozen", cpu_regs_pkg::VECTOR_BASE_DEFAULT, fetch_addr_o);
        ce_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("flags", cpu_regs_pkg::PSW_RESET, 16'(flags_o));
        chk("pc", cpu_regs_pkg::PC_RESET, fetch_addr_o);
    endtask

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        {reg_wr_i, reg_rd_i, fetch_adv_i, jump_i, alu_en_i, alu_byte_i, acc_load_i, load_byte_i} = 8'h00;
        {acc_to_tmp_i, stack_push_i, stack_pop_i, irq_req_i} = 4'h0;
        {reg_addr_i, reg_wdata_i, fetch_len_i, jump_addr_i, alu_op_i, acc_load_data_i} = '0;
        {index_disp_i, bank_reg_sel_i, mem_addr_i, irq_level_i} = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_alu();
        t_fetch();
        t_region();
        t_bank_irq();
        t_ptrs();
        t_rerst();
        conclude();
    end
endmodule // cpu_dedicated_register_set_tb
